// ---- pkg/isa_exec_pkg.sv ----
// Purpose: Shared constants for the XOR and extended instruction execute block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit data address space
// Notes:   Byte offsets below are the AXI byte addresses
// Functional notes
// - A skip on zero inserts one empty cycle, or two when the skipped instruction is two words long.
// - xor_literal_op (0000 1010 kkkkkkkk) XORs W with the literal into W in one cycle and updates N and Z.
// - xor_register_op (0001 10da ffffffff) XORs W with the file register in one cycle, to W if d is 0, to f if 1.
// - With the bank bit 0 the access bank is used, with 1 the bank_select_reg picks the bank.
// - With the bank bit 0, extension on and f at most 5Fh, the address is software_stack_pointer plus f.
// - The extension is on after reset as on a blank part and a configuration bit turns it on or off.
// - The extension adds eight literal instructions that change or index through the pointer registers.
// - Pointer add and subtract decode as E8h and E9h with select and 6-bit literal, one cycle, no flags.
// - Select 11 acts on the software stack pointer and then returns, two cycles, no flags.
// - call_via_working_reg decodes from 0014h, takes two cycles and touches no flag.
// - move_indexed_to_absolute is EBh, 1110 1011 0zzzzzzz then 1111 plus 12-bit address, two cycles.
// - move_indexed_to_indexed is 1110 1011 1zzzzzzz then 1111 xxxx x plus 7-bit offset, two cycles.
// - push_literal_op (1110 1010 k) stores k at the stack pointer and decrements it in one cycle.
// - Pointer add adds the unsigned 6-bit literal to the selected pointer and writes it back.
// - The add-with-return form loads the PC from return_stack_top after the adjust, idle second cycle.
// - The call pushes PC+2, loads PC from the latches and W, then idles one cycle.
package isa_exec_pkg;
  localparam int unsigned ADDR_W = 12;
  // Register byte offsets
  localparam logic [7:0] OFF_INSTR    = 8'h00;
  localparam logic [7:0] OFF_INSTR2   = 8'h04;
  localparam logic [7:0] OFF_WORKING_REGISTER     = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_BSR      = 8'h10;
  localparam logic [7:0] OFF_FSR0     = 8'h14;
  localparam logic [7:0] OFF_FSR1     = 8'h18;
  localparam logic [7:0] OFF_SOFTWARE_STACK_POINTER     = 8'h1c;
  localparam logic [7:0] OFF_PC       = 8'h20;
  localparam logic [7:0] OFF_TOS      = 8'h24;
  localparam logic [7:0] OFF_PC_HIGH_LATCH   = 8'h28;
  localparam logic [7:0] OFF_PC_UPPER_LATCH   = 8'h2c;
  localparam logic [7:0] OFF_CONFIG   = 8'h30;
  localparam logic [7:0] OFF_EXECSTAT = 8'h34;
  localparam logic [7:0] OFF_MEMADDR  = 8'h38;
  localparam logic [7:0] OFF_MEMDATA  = 8'h3c;
  // Status field positions and reset values
  localparam int unsigned N_BIT       = 4;
  localparam int unsigned Z_BIT       = 2;
  localparam int unsigned BUSY_BIT    = 8;
  localparam logic        EXT_RESET   = 1'b1;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [20:0] PC_RST      = 21'h000000;
  // Opcode fields
  localparam logic [6:0]  OP_TSTSKIP  = 7'b0110011;
  localparam logic [7:0]  OP_XORLIT   = 8'h0a;
  localparam logic [5:0]  OP_XORREG   = 6'b000110;
  localparam logic [7:0]  OP_PADD     = 8'he8;
  localparam logic [7:0]  OP_PSUB     = 8'he9;
  localparam logic [7:0]  OP_PUSH_LITERAL_OP    = 8'hea;
  localparam logic [7:0]  OP_MOVS     = 8'heb;
  localparam logic [15:0] OP_CALL_VIA_WORKING_REG    = 16'h0014;
  localparam logic [1:0]  SEL_STACK   = 2'b11;
  localparam logic [7:0]  IDX_LIMIT   = 8'h5f;
  localparam logic [3:0]  ACCESS_HI   = 4'hf;
  // Instruction cycle counts and PC steps
  localparam logic [1:0]  CYC_ONE     = 2'd1;
  localparam logic [1:0]  CYC_TWO     = 2'd2;
  localparam logic [1:0]  CYC_THREE   = 2'd3;
  localparam logic [20:0] PC_WORD     = 21'd2;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_READ = 2'b01,
    S_EXEC = 2'b10
  } exec_state_type;
endpackage

// ---- pkg/exec_mem_if.sv ----
// Purpose: Data memory port between execute core and its RAM
// Assumes: Read data registered one cycle after the address
// Notes:   Single port, write and read share the address
`timescale 1ns/10ps
interface exec_mem_if;
  logic [11:0] addr;
  logic        we;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport ram  (input addr, input we, input wdata, output rdata);
endinterface

// ---- verilog/data_ram.sv ----
// Purpose: 4K x 8 data memory for the execute core
// Assumes: Synchronous write, registered read
// Notes:   Contents are not reset
`timescale 1ns/10ps
module data_ram
  import isa_exec_pkg::*;
(
  input  wire logic aclk,
  exec_mem_if.ram   bus
);
  logic [7:0] mem_array [0:(1<<ADDR_W)-1];

  // Write port and registered read
  always_ff @(posedge aclk) begin
    if (bus.we) begin
      mem_array[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem_array[bus.addr];
  end
endmodule

// ---- verilog/xor_and_extended_isa_decode.sv ----
// Purpose: Execute unit for skip-on-zero, the XOR pair and the extended literal group
// Assumes: Instructions posted over AXI4-Lite, one at a time
// Notes:   Writing the instruction register starts execution; bus writes stall while busy
`timescale 1ns/10ps
module xor_and_extended_isa_decode
  import isa_exec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  exec_mem_if u_mem_bus ();
  data_ram u_ram (.aclk(aclk), .bus(u_mem_bus.ram));

  exec_state_type state_reg;
  logic [15:0] instr_reg, instr2_reg;
  logic [7:0]  w_reg, status_reg, bsr_reg, pc_high_latch_reg, pc_upper_latch_reg;
  logic [11:0] fsr_reg [0:2];
  logic [20:0] pc_reg, tos_reg, pc_next;
  logic [1:0]  cyc_reg, cyc_next;
  logic        ext_en_reg;
  logic [11:0] memaddr_reg;
  logic        aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic [7:0]  aw_addr_reg, ar_addr_reg;
  logic [31:0] w_data_reg, wd, rdata_reg;
  logic [3:0]  w_strb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        arready_reg, rd_pend_reg, rd_go_reg, rvalid_reg;
  logic        wr_fire;

  // Register readback, shared by the read mux and the strobe merge
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    case (a)
      OFF_INSTR:    reg_view = {16'h0000, instr_reg};
      OFF_INSTR2:   reg_view = {16'h0000, instr2_reg};
      OFF_WORKING_REGISTER:     reg_view = {24'h000000, w_reg};
      OFF_STATUS:   reg_view = {24'h000000, status_reg};
      OFF_BSR:      reg_view = {24'h000000, bsr_reg};
      OFF_FSR0:     reg_view = {20'h00000, fsr_reg[0]};
      OFF_FSR1:     reg_view = {20'h00000, fsr_reg[1]};
      OFF_SOFTWARE_STACK_POINTER:     reg_view = {20'h00000, fsr_reg[2]};
      OFF_PC:       reg_view = {11'h000, pc_reg};
      OFF_TOS:      reg_view = {11'h000, tos_reg};
      OFF_PC_HIGH_LATCH:   reg_view = {24'h000000, pc_high_latch_reg};
      OFF_PC_UPPER_LATCH:   reg_view = {24'h000000, pc_upper_latch_reg};
      OFF_CONFIG:   reg_view = {31'h00000000, ext_en_reg};
      OFF_EXECSTAT: reg_view = {23'h000000, state_reg != S_IDLE, 6'h00, cyc_reg};
      OFF_MEMADDR:  reg_view = {20'h00000, memaddr_reg};
      default:      reg_view = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFF_MEMDATA);
  endfunction

  // Byte-oriented effective address: access bank, indexed, or banked
  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                           input logic ext, input logic [7:0] bank_select_reg,
                                           input logic [11:0] sp);
    if (a)
      eff_addr = {bank_select_reg[3:0], f};
    else if (ext && f <= IDX_LIMIT)
      eff_addr = sp + {4'h0, f};
    else if (f <= IDX_LIMIT)
      eff_addr = {4'h0, f};
    else
      eff_addr = {ACCESS_HI, f};
  endfunction

  // Instruction decode; extended forms vanish when the extension is off
  logic is_tst, is_xorlit, is_xorreg, is_padd, is_psub, is_push, is_move_indexed_to_absolute, is_move_indexed_to_indexed, is_call_via_working_reg;
  logic next_two_word, to_stack, tst_zero;
  logic [1:0]  psel;
  logic [11:0] sp, ea, ptr_new;
  logic [7:0]  xor_res;
  assign is_tst    = instr_reg[15:9] == OP_TSTSKIP;
  assign is_xorlit = instr_reg[15:8] == OP_XORLIT;
  assign is_xorreg = instr_reg[15:10] == OP_XORREG;
  assign is_padd   = ext_en_reg && instr_reg[15:8] == OP_PADD;
  assign is_psub   = ext_en_reg && instr_reg[15:8] == OP_PSUB;
  assign is_push   = ext_en_reg && instr_reg[15:8] == OP_PUSH_LITERAL_OP;
  assign is_move_indexed_to_absolute  = ext_en_reg && instr_reg[15:8] == OP_MOVS && !instr_reg[7];
  assign is_move_indexed_to_indexed  = ext_en_reg && instr_reg[15:8] == OP_MOVS && instr_reg[7];
  assign is_call_via_working_reg  = ext_en_reg && instr_reg == OP_CALL_VIA_WORKING_REG;
  assign next_two_word = instr2_reg[15:8] == OP_MOVS;
  assign psel     = instr_reg[7:6];
  assign to_stack = psel == SEL_STACK;
  assign sp       = fsr_reg[2];
  assign ea       = eff_addr(instr_reg[7:0], instr_reg[8], ext_en_reg, bsr_reg, sp);
  assign tst_zero = is_tst && u_mem_bus.rdata == 8'h00;
  assign xor_res  = w_reg ^ (is_xorlit ? instr_reg[7:0] : u_mem_bus.rdata);

  // Pointer add or subtract of the unsigned 6-bit literal
  always_comb begin
    logic [11:0] cur;
    cur = to_stack ? fsr_reg[2] : fsr_reg[psel];
    if (is_padd)
      ptr_new = cur + {6'h00, instr_reg[5:0]};
    else
      ptr_new = cur - {6'h00, instr_reg[5:0]};
  end

  // Next PC and instruction cycle count
  always_comb begin
    pc_next  = pc_reg + PC_WORD;
    cyc_next = CYC_ONE;
    if (tst_zero) begin
      pc_next  = pc_reg + PC_WORD + (next_two_word ? PC_WORD + PC_WORD : PC_WORD);
      cyc_next = next_two_word ? CYC_THREE : CYC_TWO;
    end else if (is_move_indexed_to_absolute || is_move_indexed_to_indexed) begin
      pc_next  = pc_reg + PC_WORD + PC_WORD;
      cyc_next = CYC_TWO;
    end else if ((is_padd || is_psub) && to_stack) begin
      pc_next  = tos_reg;
      cyc_next = CYC_TWO;
    end else if (is_call_via_working_reg) begin
      pc_next  = {pc_upper_latch_reg[4:0], pc_high_latch_reg, w_reg};
      cyc_next = CYC_TWO;
    end
  end

  // Data memory port: bus window when idle, operand read, result write
  always_comb begin
    u_mem_bus.addr  = memaddr_reg;
    u_mem_bus.we    = wr_fire && aw_addr_reg == OFF_MEMDATA;
    u_mem_bus.wdata = wd[7:0];
    if (state_reg == S_READ) begin
      u_mem_bus.addr = (is_move_indexed_to_absolute || is_move_indexed_to_indexed) ? sp + {5'h00, instr_reg[6:0]} : ea;
    end else if (state_reg == S_EXEC) begin
      u_mem_bus.we    = (is_xorreg && instr_reg[9]) || is_move_indexed_to_absolute || is_move_indexed_to_indexed || is_push;
      u_mem_bus.wdata = is_push ? instr_reg[7:0] : (is_xorreg ? xor_res : u_mem_bus.rdata);
      if (is_move_indexed_to_absolute)
        u_mem_bus.addr = instr2_reg[11:0];
      else if (is_move_indexed_to_indexed)
        u_mem_bus.addr = sp + {5'h00, instr2_reg[6:0]};
      else if (is_push)
        u_mem_bus.addr = sp;
      else
        u_mem_bus.addr = ea;
    end
  end

  // Write data merged under byte strobes
  always_comb begin
    logic [31:0] cur;
    cur = reg_view(aw_addr_reg);
    for (int i = 0; i < 4; i++) begin
      wd[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : cur[i*8 +: 8];
    end
  end
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg && state_reg == S_IDLE;

  // Write address and data capture, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready_reg) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (mapped(aw_addr_reg) && aw_addr_reg != OFF_EXECSTAT) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read channel; data taken once the core is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rd_pend_reg <= 1'b0;
      rd_go_reg   <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
      ar_addr_reg <= 8'h00;
    end else begin
      rd_go_reg <= 1'b0;
      if (arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rd_pend_reg <= 1'b1;
        ar_addr_reg <= araddr;
      end
      if (rd_pend_reg && state_reg == S_IDLE && !wr_fire) begin
        rd_pend_reg <= 1'b0;
        rd_go_reg   <= 1'b1;
      end
      if (rd_go_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= (ar_addr_reg == OFF_MEMDATA) ? {24'h000000, u_mem_bus.rdata} : reg_view(ar_addr_reg);
        rresp_reg  <= mapped(ar_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_reg && rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Sequencer: operand read then execute
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: if (wr_fire && aw_addr_reg == OFF_INSTR) state_reg <= S_READ;
        S_READ: state_reg <= S_EXEC;
        S_EXEC: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Architectural registers: bus writes when idle, results in execute
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg   <= 16'h0000;
      instr2_reg  <= 16'h0000;
      w_reg       <= 8'h00;
      status_reg  <= STATUS_RST;
      bsr_reg     <= 8'h00;
      fsr_reg[0]  <= 12'h000;
      fsr_reg[1]  <= 12'h000;
      fsr_reg[2]  <= 12'h000;
      pc_reg      <= PC_RST;
      tos_reg     <= PC_RST;
      pc_high_latch_reg  <= 8'h00;
      pc_upper_latch_reg  <= 8'h00;
      ext_en_reg  <= EXT_RESET;
      cyc_reg     <= 2'd0;
      memaddr_reg <= 12'h000;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        OFF_INSTR:   instr_reg   <= wd[15:0];
        OFF_INSTR2:  instr2_reg  <= wd[15:0];
        OFF_WORKING_REGISTER:    w_reg       <= wd[7:0];
        OFF_STATUS:  status_reg  <= wd[7:0];
        OFF_BSR:     bsr_reg     <= wd[7:0];
        OFF_FSR0:    fsr_reg[0]  <= wd[11:0];
        OFF_FSR1:    fsr_reg[1]  <= wd[11:0];
        OFF_SOFTWARE_STACK_POINTER:    fsr_reg[2]  <= wd[11:0];
        OFF_PC:      pc_reg      <= wd[20:0];
        OFF_TOS:     tos_reg     <= wd[20:0];
        OFF_PC_HIGH_LATCH:  pc_high_latch_reg  <= wd[7:0];
        OFF_PC_UPPER_LATCH:  pc_upper_latch_reg  <= wd[7:0];
        OFF_CONFIG:  ext_en_reg  <= wd[0];
        OFF_MEMADDR: memaddr_reg <= wd[11:0];
        default: ;
      endcase
    end else if (state_reg == S_EXEC) begin
      pc_reg  <= pc_next;
      cyc_reg <= cyc_next;
      if (is_xorlit || (is_xorreg && !instr_reg[9]))
        w_reg <= xor_res;
      if (is_xorlit || is_xorreg) begin
        status_reg[N_BIT] <= xor_res[7];
        status_reg[Z_BIT] <= xor_res == 8'h00;
      end
      if ((is_padd || is_psub) && to_stack)
        fsr_reg[2] <= ptr_new;
      else if (is_padd || is_psub)
        fsr_reg[psel] <= ptr_new;
      if (is_push)
        fsr_reg[2] <= sp - 12'h001;
      if (is_call_via_working_reg)
        tos_reg <= pc_reg + PC_WORD;
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Checks on the operand read and execute steps
  logic ex;
  assign ex = state_reg == S_EXEC;

  property p_skip_cycles;
    @(posedge aclk) disable iff (!aresetn)
    ex && tst_zero |=> cyc_reg == ($past(next_two_word) ? CYC_THREE : CYC_TWO);
  endproperty
  a_skip_cycles: assert property (p_skip_cycles) else $error("skip cycle count wrong");

  property p_xor_lit;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_xorlit |=> w_reg == ($past(w_reg) ^ $past(instr_reg[7:0])) && state_reg == S_IDLE;
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal XOR result wrong");

  property p_xor_to_file;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_xorreg && instr_reg[9] |-> u_mem_bus.we && u_mem_bus.wdata == (w_reg ^ u_mem_bus.rdata)
      ##1 w_reg == $past(w_reg);
  endproperty
  a_xor_to_file: assert property (p_xor_to_file) else $error("file XOR destination wrong");

  property p_bank_sel;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == S_READ && is_xorreg && instr_reg[8] |-> u_mem_bus.addr == {bsr_reg[3:0], instr_reg[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

  property p_indexed;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == S_READ && (is_xorreg || is_tst) && !instr_reg[8] && ext_en_reg && instr_reg[7:0] <= IDX_LIMIT
      |-> u_mem_bus.addr == sp + {4'h0, instr_reg[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed literal offset address wrong");

  property p_flags;
    @(posedge aclk) disable iff (!aresetn)
    ex && (is_xorlit || is_xorreg) |=> status_reg[Z_BIT] == ($past(xor_res) == 8'h00)
      && status_reg[N_BIT] == $past(xor_res[7]);
  endproperty
  a_flags: assert property (p_flags) else $error("XOR flags wrong");

  property p_no_flags;
    @(posedge aclk) disable iff (!aresetn)
    ex && (is_padd || is_psub || is_push || is_call_via_working_reg || is_move_indexed_to_absolute || is_move_indexed_to_indexed) |=> $stable(status_reg);
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("extended op changed status");

  property p_stack_ret;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_padd && to_stack |=> pc_reg == $past(tos_reg) && cyc_reg == CYC_TWO
      && fsr_reg[2] == $past(sp) + {6'h00, $past(instr_reg[5:0])};
  endproperty
  a_stack_ret: assert property (p_stack_ret) else $error("add and return wrong");

  property p_call_via_working_reg;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_call_via_working_reg |=> tos_reg == $past(pc_reg) + PC_WORD
      && pc_reg == {$past(pc_upper_latch_reg[4:0]), $past(pc_high_latch_reg), $past(w_reg)};
  endproperty
  a_call_via_working_reg: assert property (p_call_via_working_reg) else $error("call through W wrong");

  property p_push;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_push |-> u_mem_bus.we && u_mem_bus.addr == sp && u_mem_bus.wdata == instr_reg[7:0]
      ##1 fsr_reg[2] == $past(sp) - 12'h001;
  endproperty
  a_push: assert property (p_push) else $error("push literal wrong");

  property p_move_indexed_to_absolute;
    @(posedge aclk) disable iff (!aresetn)
    ex && is_move_indexed_to_absolute |-> u_mem_bus.we && u_mem_bus.addr == instr2_reg[11:0] ##1 pc_reg == $past(pc_reg) + 21'd4;
  endproperty
  a_move_indexed_to_absolute: assert property (p_move_indexed_to_absolute) else $error("indexed to absolute move wrong");
endmodule

// ---- verif/xor_and_extended_isa_decode_bench.sv ----
// Purpose: Self-checking bench for the XOR and extended instruction execute block
// Assumes: Instructions posted over AXI4-Lite; data RAM reached via MEMADDR/MEMDATA
// Notes:   Expected values worked out by hand from the instruction semantics
`timescale 1ns/10ps
module xor_and_extended_isa_decode_bench
  import isa_exec_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  int          num_errors, n_checks, cycles;

  xor_and_extended_isa_decode dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Clock at 100 MHz
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard, far above the expected run length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end

  task stop_test;
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wready && !tw) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task ex(input logic [15:0] op); wr(8'h00, {16'h0000, op}); endtask
  task mw(input logic [11:0] a, input logic [7:0] d); wr(8'h38, {20'h0, a}); wr(8'h3c, {24'h0, d}); endtask
  task mr(input logic [11:0] a, input logic [7:0] e); wr(8'h38, {20'h0, a}); rc(8'h3c, {24'h0, e}); endtask

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    num_errors = 0; n_checks = 0; cycles = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h30, 32'h1);
    rd(8'h40, rd_val);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    chk(rd_val, 32'h0);
    wr(8'h08, 32'hb5); ex(16'h0aaf); rc(8'h08, 32'h1a);
    rc(8'h0c, 32'h00);
    ex(16'h0a1a); rc(8'h0c, 32'h04);
    ex(16'h0a80); rc(8'h0c, 32'h10);
    rc(8'h34, 32'h1);
    wr(8'h34, 32'h0);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    rc(8'h34, 32'h1);
    wr(8'h10, 32'h2); mw(12'h210, 8'haf); wr(8'h08, 32'hb5); ex(16'h1b10);
    mr(12'h210, 8'h1a);
    rc(8'h08, 32'hb5);
    wr(8'h1c, 32'h100); mw(12'h105, 8'hb5); ex(16'h1805); rc(8'h08, 32'h00);
    mw(12'hf80, 8'h0f); ex(16'h1880); rc(8'h08, 32'h0f);
    wr(8'h30, 32'h0); mw(12'h005, 8'hf0); ex(16'h1805); rc(8'h08, 32'hff);
    wr(8'h30, 32'h1);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    wr(8'h1c, 32'h3ff); ex(16'he8a3); rc(8'h1c, 32'h422);
    rc(8'h0c, 32'h10);
    wr(8'h14, 32'h100); ex(16'he93f); rc(8'h14, 32'h0c1);
    wr(8'h24, 32'h1234); ex(16'he8c1); rc(8'h1c, 32'h423);
    rc(8'h20, 32'h1234);
    rc(8'h34, 32'h2);
    ex(16'he9c3); rc(8'h1c, 32'h420);
    wr(8'h08, 32'h06); wr(8'h28, 32'h10); wr(8'h2c, 32'h0); wr(8'h20, 32'h100);
    ex(16'h0014); rc(8'h20, 32'h1006);
    rc(8'h24, 32'h102);
    rc(8'h34, 32'h2);
    wr(8'h1c, 32'h200); ex(16'hea5a); mr(12'h200, 8'h5a);
    rc(8'h1c, 32'h1ff);
    mw(12'h204, 8'h77); wr(8'h04, 32'hf123); wr(8'h20, 32'h0); ex(16'heb05);
    mr(12'h123, 8'h77);
    rc(8'h20, 32'h4);
    wr(8'h04, 32'hf006); ex(16'heb85); mr(12'h205, 8'h77);
    rc(8'h34, 32'h2);
    // Skip: not zero, zero, zero over a two-word move
    wr(8'h04, 32'h0); wr(8'h20, 32'h100); ex(16'h6710); rc(8'h20, 32'h102);
    mw(12'h210, 8'h00); wr(8'h20, 32'h100); ex(16'h6710); rc(8'h34, 32'h2);
    rc(8'h20, 32'h104);
    wr(8'h04, 32'heb00); wr(8'h20, 32'h100); ex(16'h6710); rc(8'h34, 32'h3);
    rc(8'h20, 32'h106);
    stop_test;
  end
endmodule
